// [inc/svm_pkg.sv]
// Package for the supply voltage monitor control block
// ---------------------------------------------------------------------------
// Summary of operation
// R1 - Detector runs only while monitor_enable (bit 4) is set; else no events
// R2 - Each enable rising edge restarts the stabilisation interval
// R3 - reference_stable (bit 5) is read-only, 0 until settled, then 1
// R4 - Event flag is suppressed while reference_stable is 0
// R5 - trip_direction 0 detects at-or-below; 1 detects at-or-above
// R6 - Crossing the trip point in the chosen direction sets the event flag
// R7 - trip_level picks tap; 1111 external pin, 1110 highest, 0000 lowest
// R8 - bandgap_stable (bit 6) is a read-only band-gap stable flag
// R9 - Reset returns control bits to reset values, turning detector off
// R10 - Software should disable before changing direction or level
// R11 - Detector keeps running in sleep; a trip sets the flag and wakes
// R12 - Event flag is bit 2 of the flag register, sticky until cleared
// R13 - Clearing monitor_enable clears reference_stable at once
// ---------------------------------------------------------------------------
package svm_pkg;

  // Register byte offsets
  localparam logic [11:0] CTRL_OFF = 12'h000;
  localparam logic [11:0] FLAG_OFF = 12'h004;
  localparam logic [11:0] MASK_OFF = 12'h008;

  // Control, flag and mask register fields
  localparam int DIR_BIT    = 7;
  localparam int BGS_BIT    = 6;
  localparam int RST_BIT    = 5;
  localparam int EN_BIT     = 4;
  localparam int LVL_LSB    = 0;
  localparam int EVT_BIT    = 2;

  // Reset values
  localparam logic [7:0] CTRL_RST = 8'h04;
  localparam logic [7:0] MASK_RST = 8'h00;

  // Trip level codes
  localparam logic [3:0] LVL_EXT = 4'hF;

  // Settling time of the reference after enabling
  localparam int SETTLE_NS     = 1000;
  localparam int CLK_PERIOD_NS = 4;
  localparam int SETTLE_CYC    = (SETTLE_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
  localparam int CNT_W         = 8;

endpackage

// [src/svm_settle.sv]
// Settling timer for the detector reference after each enable
`timescale 1ns/1ns
module svm_settle
(
  // Clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // Control
  input  wire logic             enable,
  // Status
  output logic                  stable
);

  logic [svm_pkg::CNT_W-1:0] cnt_r;
  logic                      en_d_r;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      en_d_r <= 1'b0;
    else
      en_d_r <= enable;
  end

  // Restart on every enable rising edge; drop at once on disable
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_r  <= '0;
      stable <= 1'b0;
    end
    else if (!enable)
    begin
      cnt_r  <= '0;
      stable <= 1'b0; // R13
    end
    else if (!en_d_r)
    begin
      cnt_r  <= '0; // R2
      stable <= 1'b0;
    end
    else if (cnt_r == svm_pkg::CNT_W'(svm_pkg::SETTLE_CYC - 1))
      stable <= 1'b1; // R3
    else
      cnt_r <= cnt_r + 1'b1;
  end

  property p_restart;
    @(posedge pclk) disable iff (!presetn)
      $rose(enable) |=> !stable;
  endproperty
  a_restart: assert property (p_restart) // R2
    else $error("stable not cleared on enable");

  property p_drop;
    @(posedge pclk) disable iff (!presetn)
      !enable |=> !stable;
  endproperty
  a_drop: assert property (p_drop) // R13
    else $error("stable held while disabled");

endmodule

// [src/svm_top.sv]
// Supply voltage monitor control with APB register access
//
// Added by the designer: the APB register port and the placing of the registers.
`timescale 1ns/1ns
module svm_top
(
  // APB slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Analog front end
  input  wire logic        cmp_below,
  input  wire logic        cmp_above,
  input  wire logic        bandgap_ok,
  output logic             detector_power,
  output logic [3:0]       trip_level,
  output logic             ext_trip_select,
  // System
  output logic             irq,
  output logic             wake
);

  // -------------------------------------------------------------------------
  // Input synchronisers
  // -------------------------------------------------------------------------
  logic [2:0] meta_r;
  logic [2:0] sync_r;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_r <= '0;
      sync_r <= '0;
    end
    else
    begin
      meta_r <= {bandgap_ok, cmp_above, cmp_below};
      sync_r <= meta_r;
    end
  end

  logic below_s;
  logic above_s;
  logic bgs_s;
  assign below_s = sync_r[0];
  assign above_s = sync_r[1];
  assign bgs_s   = sync_r[2];

  // -------------------------------------------------------------------------
  // Registers
  // -------------------------------------------------------------------------
  logic       dir_r;
  logic       en_r;
  logic [3:0] lvl_r;
  logic       evt_r;
  logic       mask_r;
  logic       ref_stable;
  logic       wr;
  logic       rd;

  assign wr = psel && penable && pwrite;
  assign rd = psel && !penable && !pwrite;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dir_r <= svm_pkg::CTRL_RST[svm_pkg::DIR_BIT]; // R9
      en_r  <= svm_pkg::CTRL_RST[svm_pkg::EN_BIT];
      lvl_r <= svm_pkg::CTRL_RST[svm_pkg::LVL_LSB +: 4];
    end
    else if (wr && paddr == svm_pkg::CTRL_OFF)
    begin
      dir_r <= pwdata[svm_pkg::DIR_BIT];
      en_r  <= pwdata[svm_pkg::EN_BIT]; // R1
      lvl_r <= pwdata[svm_pkg::LVL_LSB +: 4];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mask_r <= svm_pkg::MASK_RST[svm_pkg::EVT_BIT];
    else if (wr && paddr == svm_pkg::MASK_OFF)
      mask_r <= pwdata[svm_pkg::EVT_BIT];
  end

  svm_settle u_settle
  (
    .pclk    (pclk),
    .presetn (presetn),
    .enable  (en_r),
    .stable  (ref_stable)
  );

  // -------------------------------------------------------------------------
  // Trip detection
  // -------------------------------------------------------------------------
  // Comparator outputs are at-or-below / at-or-above the selected tap
  logic hit;
  logic trip;
  assign hit  = dir_r ? above_s : below_s; // R5
  assign trip = en_r && ref_stable && hit; // R4

  // Set wins over a software clear in the same cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      evt_r <= 1'b0;
    else if (trip)
      evt_r <= 1'b1; // R6 R12
    else if (wr && paddr == svm_pkg::FLAG_OFF && pwdata[svm_pkg::EVT_BIT])
      evt_r <= 1'b0;
  end

  // -------------------------------------------------------------------------
  // Outputs
  // -------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      detector_power  <= 1'b0;
      trip_level      <= 4'h0;
      ext_trip_select <= 1'b0;
      irq             <= 1'b0;
      wake            <= 1'b0;
    end
    else
    begin
      detector_power  <= en_r; // R1 R11
      trip_level      <= lvl_r; // R7
      ext_trip_select <= (lvl_r == svm_pkg::LVL_EXT); // R7
      irq             <= evt_r && mask_r;
      wake            <= trip; // R11
    end
  end

  // -------------------------------------------------------------------------
  // APB read path: no wait states, data registered in setup
  // -------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && paddr != svm_pkg::CTRL_OFF
                 && paddr != svm_pkg::FLAG_OFF
                 && paddr != svm_pkg::MASK_OFF;
      if (rd)
      begin
        prdata <= 32'h0000_0000;
        unique case (paddr)
          svm_pkg::CTRL_OFF:
            prdata[7:0] <= {dir_r, bgs_s, ref_stable, en_r, lvl_r}; // R3 R8
          svm_pkg::FLAG_OFF:
            prdata[svm_pkg::EVT_BIT] <= evt_r;
          svm_pkg::MASK_OFF:
            prdata[svm_pkg::EVT_BIT] <= mask_r;
          default:
            prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // -------------------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------------------
  property p_off_quiet;
    @(posedge pclk) disable iff (!presetn)
      (!en_r && !evt_r) |=> !evt_r;
  endproperty
  a_off_quiet: assert property (p_off_quiet) // R1
    else $error("event while disabled");

  property p_no_unstable;
    @(posedge pclk) disable iff (!presetn)
      (!ref_stable && !evt_r) |=> !evt_r;
  endproperty
  a_no_unstable: assert property (p_no_unstable) // R4
    else $error("event before reference stable");

  property p_set;
    @(posedge pclk) disable iff (!presetn)
      (en_r && ref_stable && (dir_r ? above_s : below_s)) |=> evt_r;
  endproperty
  a_set: assert property (p_set) // R6
    else $error("trip did not set flag");

  property p_sticky;
    @(posedge pclk) disable iff (!presetn)
      (evt_r && !(wr && paddr == svm_pkg::FLAG_OFF)) |=> evt_r;
  endproperty
  a_sticky: assert property (p_sticky) // R12
    else $error("flag lost without clear");

  property p_ext;
    @(posedge pclk) disable iff (!presetn)
      (lvl_r == 4'hF) |=> ext_trip_select;
  endproperty
  a_ext: assert property (p_ext) // R7
    else $error("external input not selected");

  property p_settle;
    @(posedge pclk) disable iff (!presetn)
      $rose(en_r) |-> !ref_stable [*8];
  endproperty
  a_settle: assert property (p_settle) // R3
    else $error("stable too early");

  property p_dir;
    @(posedge pclk) disable iff (!presetn)
      (en_r && ref_stable && dir_r && above_s) |=> wake;
  endproperty
  a_dir: assert property (p_dir) // R5
    else $error("rising trip missed");

  property p_wake;
    @(posedge pclk) disable iff (!presetn)
      wake |-> evt_r;
  endproperty
  a_wake: assert property (p_wake) // R11
    else $error("wake without flag");

  // -------------------------------------------------------------------------
  // Check helpers
  // -------------------------------------------------------------------------
  // Saturating age of the enable; a counter stands in for
  // a repetition hundreds of cycles long
  logic [svm_pkg::CNT_W:0] en_age_r;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      en_age_r <= '0;
    else if (!en_r)
      en_age_r <= '0;
    else if (en_age_r != '1)
      en_age_r <= en_age_r + 1'b1;
  end

  sequence s_setup;
    psel && !penable;
  endsequence

  sequence s_enable_rise;
    !en_r ##1 en_r;
  endsequence

  sequence s_ctrl_write;
    wr && paddr == svm_pkg::CTRL_OFF;
  endsequence

  sequence s_flag_read;
    rd && paddr == svm_pkg::FLAG_OFF;
  endsequence

  property p_answer;
    @(posedge pclk) disable iff (!presetn)
      s_setup |=> pready;
  endproperty
  a_answer: assert property (p_answer)
    else $error("no ready after setup");

  property p_ready_pulse;
    @(posedge pclk) disable iff (!presetn)
      pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse)
    else $error("ready longer than one cycle");

  property p_err_ready;
    @(posedge pclk) disable iff (!presetn)
      pslverr |-> pready;
  endproperty
  a_err_ready: assert property (p_err_ready)
    else $error("error without ready");

  property p_ctrl_wr;
    @(posedge pclk) disable iff (!presetn)
      s_ctrl_write |=> (en_r == $past(pwdata[svm_pkg::EN_BIT]));
  endproperty
  a_ctrl_wr: assert property (p_ctrl_wr) // R1
    else $error("enable write lost");

  property p_power;
    @(posedge pclk) disable iff (!presetn)
      en_r |=> detector_power;
  endproperty
  a_power: assert property (p_power) // R1
    else $error("detector not powered");

  property p_fall_drop;
    @(posedge pclk) disable iff (!presetn)
      $fell(en_r) |=> !ref_stable;
  endproperty
  a_fall_drop: assert property (p_fall_drop) // R13
    else $error("stable kept after disable");

  property p_hold_off;
    @(posedge pclk) disable iff (!presetn)
      (s_enable_rise ##0 !evt_r) |=> !evt_r [*8];
  endproperty
  a_hold_off: assert property (p_hold_off) // R4
    else $error("event during settling");

  property p_stable_late;
    @(posedge pclk) disable iff (!presetn)
      ref_stable |-> (en_age_r >= (svm_pkg::CNT_W + 1)'(svm_pkg::SETTLE_CYC));
  endproperty
  a_stable_late: assert property (p_stable_late) // R3
    else $error("stable before settling time");

  property p_stable_due;
    @(posedge pclk) disable iff (!presetn)
      (en_r && en_age_r == (svm_pkg::CNT_W + 1)'(svm_pkg::SETTLE_CYC + 2))
        |-> ref_stable;
  endproperty
  a_stable_due: assert property (p_stable_due) // R3
    else $error("not stable after settling time");

  property p_ro_bits;
    @(posedge pclk) disable iff (!presetn)
      (s_ctrl_write ##0 !en_r) |=> !ref_stable;
  endproperty
  a_ro_bits: assert property (p_ro_bits) // R3
    else $error("stable bit set by a write");

  property p_clear;
    @(posedge pclk) disable iff (!presetn)
      (evt_r && !trip && wr && paddr == svm_pkg::FLAG_OFF
        && pwdata[svm_pkg::EVT_BIT]) |=> !evt_r;
  endproperty
  a_clear: assert property (p_clear) // R12
    else $error("flag not cleared by write");

  property p_flag_rd;
    @(posedge pclk) disable iff (!presetn)
      s_flag_read |=> (prdata[svm_pkg::EVT_BIT] == $past(evt_r));
  endproperty
  a_flag_rd: assert property (p_flag_rd) // R12
    else $error("flag read back wrong");

  property p_irq;
    @(posedge pclk) disable iff (!presetn)
      (evt_r && mask_r) |=> irq;
  endproperty
  a_irq: assert property (p_irq)
    else $error("unmasked flag raised no irq");

endmodule

// [sim/svm_rail.sv]
// Behavioural supply rail and trip comparator facing the monitor
`timescale 1ns/1ns
module svm_rail
(
  // Bench stimulus
  input  wire logic [11:0] supply,
  input  wire logic [11:0] ext_level,
  input  wire logic        bg_in,
  // Selection from the monitor
  input  wire logic [3:0]  trip_level,
  input  wire logic        ext_trip_select,
  // Comparator outputs
  output logic             cmp_below,
  output logic             cmp_above,
  output logic             bandgap_ok
);
  logic [11:0] thr;
  // Taps rise with the code; the top code takes the pin instead
  assign thr = ext_trip_select ? ext_level
             : 12'h064 + 12'(trip_level) * 12'h00A;
  // Comparator runs even when unpowered, so gating is the monitor's job
  assign cmp_below  = (supply <= thr);
  assign cmp_above  = (supply >= thr);
  assign bandgap_ok = bg_in;
endmodule

// [sim/tb_top.sv]
// Self-checking bench for the supply voltage monitor control block
`timescale 1ns/1ns
module tb_top;
  typedef struct packed {
    logic        dir;
    logic [3:0]  lvl;
    logic [11:0] sup;
    logic [11:0] ext;
    logic        hit;
  } svm_row_s;
  localparam svm_row_s ROWS [6] = '{
    '{1'b0, 4'h0, 12'h064, 12'h000, 1'b1},
    '{1'b0, 4'h0, 12'h065, 12'h000, 1'b0},
    '{1'b1, 4'hE, 12'h0F0, 12'h000, 1'b1},
    '{1'b1, 4'hE, 12'h0EF, 12'h000, 1'b0},
    '{1'b0, 4'hF, 12'h12C, 12'h12C, 1'b1},
    '{1'b1, 4'hF, 12'h104, 12'h12C, 1'b0}};
  logic        pclk, presetn, psel, penable, pwrite;
  logic [11:0] paddr, sup, ext;
  logic [31:0] pwdata, prdata, r;
  logic        pready, pslverr, e, bg_in, wake_seen, wake_clr;
  logic        cmp_below, cmp_above, bandgap_ok;
  logic        detector_power, ext_trip_select, irq, wake;
  logic [3:0]  trip_level;
  int          num_errors, tests_run, cycles;

  svm_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cmp_below(cmp_below), .cmp_above(cmp_above), .bandgap_ok(bandgap_ok),
    .detector_power(detector_power), .trip_level(trip_level),
    .ext_trip_select(ext_trip_select), .irq(irq), .wake(wake));
  svm_rail rail (.supply(sup), .ext_level(ext), .bg_in(bg_in),
    .trip_level(trip_level), .ext_trip_select(ext_trip_select),
    .cmp_below(cmp_below), .cmp_above(cmp_above), .bandgap_ok(bandgap_ok));

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic end_sim;
    if (num_errors == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Slave latency is not assumed; the wait ends on pready or at the bound of 20 cycles
    do
    begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) chk(32'h0, 32'h1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(r, exp);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // ---------------------------------------------------------------
  // Clock, wake monitor
  // ---------------------------------------------------------------
  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  // Wake is high only while a trip is present, so it is latched here for the sequence
  always @(posedge pclk)
  begin
    if (wake_clr)
      wake_seen <= 1'b0;
    else if (wake === 1'b1)
      wake_seen <= 1'b1;
  end

  // ---------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------
  task automatic run_all;
    cyc(10);
    presetn <= 1'b1;
    rd(svm_pkg::CTRL_OFF, 32'h04);
    rd(svm_pkg::MASK_OFF, 32'h0);
    chk({irq, detector_power}, 2'b00);
    foreach (ROWS[i])
    begin
      svm_row_s row;
      row = ROWS[i];
      apb(1'b1, svm_pkg::CTRL_OFF, {24'h0, row.dir, 3'b000, row.lvl});
      sup <= row.sup;
      ext <= row.ext;
      apb(1'b1, svm_pkg::FLAG_OFF, 32'h4);
      apb(1'b1, svm_pkg::CTRL_OFF, {24'h0, row.dir, 3'b001, row.lvl});
      cyc(260);
      chk({ext_trip_select, trip_level}, {row.lvl == 4'hF, row.lvl});
      rd(svm_pkg::FLAG_OFF, {29'h0, row.hit, 2'b00});
    end
    // Trip present from the start: held off until settled
    bg_in <= 1'b1;
    apb(1'b1, svm_pkg::CTRL_OFF, 32'h00);
    sup <= 12'h032;
    apb(1'b1, svm_pkg::FLAG_OFF, 32'h4);
    wake_clr <= 1'b1;
    cyc(1);
    wake_clr <= 1'b0;
    apb(1'b1, svm_pkg::CTRL_OFF, 32'h70);
    rd(svm_pkg::CTRL_OFF, 32'h50);
    rd(svm_pkg::FLAG_OFF, 32'h0);
    chk({31'h0, wake_seen}, 32'h0);
    cyc(250);
    rd(svm_pkg::CTRL_OFF, 32'h70);
    rd(svm_pkg::FLAG_OFF, 32'h4);
    chk({31'h0, wake_seen}, 32'h1);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, svm_pkg::MASK_OFF, 32'h4);
    cyc(2);
    chk({31'h0, irq}, 32'h1);
    // Condition gone: the flag stays until written with a one
    sup <= 12'h200;
    cyc(6);
    rd(svm_pkg::FLAG_OFF, 32'h4);
    apb(1'b1, svm_pkg::FLAG_OFF, 32'h4);
    cyc(2);
    chk({31'h0, irq}, 32'h0);
    // Disable drops stability at once and blocks events
    apb(1'b1, svm_pkg::CTRL_OFF, 32'h60);
    sup <= 12'h032;
    rd(svm_pkg::CTRL_OFF, 32'h40);
    chk({31'h0, detector_power}, 32'h0);
    cyc(300);
    rd(svm_pkg::FLAG_OFF, 32'h0);
    rd(12'h00C, 32'h0);
    chk({31'h0, e}, 32'h1);
    bg_in <= 1'b0;
    cyc(4);
    rd(svm_pkg::CTRL_OFF, 32'h00);
    apb(1'b1, svm_pkg::CTRL_OFF, 32'h93);
    presetn <= 1'b0;
    cyc(2);
    presetn <= 1'b1;
    rd(svm_pkg::CTRL_OFF, 32'h04);
    chk({31'h0, detector_power}, 32'h0);
  endtask

  initial
  begin
    presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    sup = 12'h200; ext = 0; bg_in = 0; wake_clr = 1;
    num_errors = 0; tests_run = 0; cycles = 0;
    fork
      run_all();
      // Ceiling far above the few thousand cycles the sequence needs
      begin
        while (cycles < 12000)
        begin
          @(posedge pclk);
          cycles++;
        end
        num_errors++;
      end
    join_any
    end_sim;
  end
endmodule
